// [ssr_sram_cycles.v]
// Bus-cycle logic of a pipelined synchronous SRAM without turnaround cycles
`timescale 1ns/1ps
`include "ssr_regs.vh"

module ssr_sram_cycles (
  // Clock and reset
  input  wire                     clk,
  input  wire                     reset,
  // Cycle control
  input  wire                     clk_enable_n,
  input  wire                     chip_select_n,
  input  wire                     chip_select2_n,
  input  wire                     chip_select_high,
  input  wire                     advance_load_n,
  input  wire                     read_write,
  input  wire [`SSR_ADDR_W-1:0]   address,
  // Lane write enables
  input  wire                     byte_lane0_write_n,
  input  wire                     byte_lane1_write_n,
  input  wire                     byte_lane2_write_n,
  input  wire                     byte_lane3_write_n,
  // Static and asynchronous controls
  input  wire                     output_enable_n,
  input  wire                     burst_order,
  input  wire                     sleep_request,
  // Data lane 0
  input  wire [`SSR_LANE_W-1:0]   data_lane0_in,
  output wire [`SSR_LANE_W-1:0]   data_lane0_out,
  output wire                     data_lane0_oe_n,
  // Data lane 1
  input  wire [`SSR_LANE_W-1:0]   data_lane1_in,
  output wire [`SSR_LANE_W-1:0]   data_lane1_out,
  output wire                     data_lane1_oe_n,
  // Data lane 2
  input  wire [`SSR_LANE_W-1:0]   data_lane2_in,
  output wire [`SSR_LANE_W-1:0]   data_lane2_out,
  output wire                     data_lane2_oe_n,
  // Data lane 3
  input  wire [`SSR_LANE_W-1:0]   data_lane3_in,
  output wire [`SSR_LANE_W-1:0]   data_lane3_out,
  output wire                     data_lane3_oe_n
);

  // Burst low address: interleaved XOR or linear add
  function [`SSR_BURST_W-1:0] burst_lo;
    input [`SSR_BURST_W-1:0] start;
    input [`SSR_BURST_W-1:0] count;
    input                    interleave;
    begin
      if (interleave) begin
        burst_lo = start ^ count;
      end else begin
        burst_lo = start + count;
      end
    end
  endfunction

  // Overlay enabled lanes of newer data on older data
  function [`SSR_DATA_W-1:0] lane_merge;
    input [`SSR_DATA_W-1:0] old_data;
    input [`SSR_DATA_W-1:0] new_data;
    input [`SSR_LANES-1:0]  lanes;
    integer i;
    begin
      lane_merge = old_data;
      for (i = 0; i < `SSR_LANES; i = i + 1) begin
        if (lanes[i]) begin
          lane_merge[i*`SSR_LANE_W +: `SSR_LANE_W] = new_data[i*`SSR_LANE_W +: `SSR_LANE_W];
        end
      end
    end
  endfunction

  // Storage index: upper address bits alias onto the small array
  function [`SSR_MEM_AW-1:0] word_index;
    input [`SSR_ADDR_W-1:0] addr;
    begin
      word_index = addr[`SSR_MEM_AW-1:0];
    end
  endfunction

  // One data lane out of a full word
  function [`SSR_LANE_W-1:0] lane_of;
    input [`SSR_DATA_W-1:0] word;
    input [1:0]             lane;
    begin
      lane_of = word[lane*`SSR_LANE_W +: `SSR_LANE_W];
    end
  endfunction

  // Sleep states: awake, asleep, draining the commit buffer
  localparam SLP_AWAKE  = 2'h0;
  localparam SLP_ASLEEP = 2'h1;
  localparam SLP_DRAIN  = 2'h2;

  // Burst state
  reg [1:0]               burst_type_q;
  reg [1:0]               burst_type_d;
  reg [`SSR_ADDR_W-1:0]   base_q;
  reg [`SSR_ADDR_W-1:0]   base_d;
  reg [`SSR_BURST_W-1:0]  cnt_q;
  reg [`SSR_BURST_W-1:0]  cnt_d;

  // Pipeline stages
  reg [1:0]               s1_type_q;
  reg [`SSR_ADDR_W-1:0]   s1_addr_q;
  reg [`SSR_LANES-1:0]    s1_lanes_q;
  reg [1:0]               s2_type_q;
  reg [`SSR_ADDR_W-1:0]   s2_addr_q;
  reg [`SSR_LANES-1:0]    s2_lanes_q;
  reg                     s3_wr_q;
  reg [`SSR_ADDR_W-1:0]   s3_addr_q;
  reg [`SSR_LANES-1:0]    s3_lanes_q;

  // Output side and sleep recovery
  reg [`SSR_DATA_W-1:0]   out_q;
  reg                     drive_q;
  reg [1:0]               slp_q;
  reg [1:0]               slp_d;

  // New cycle decode
  reg [1:0]               c_type;
  reg [`SSR_ADDR_W-1:0]   c_addr;

  // Storage array
  reg [`SSR_DATA_W-1:0]   mem_q [0:`SSR_MEM_DEPTH-1];

  // Buffer wiring
  wire                    fifo_in_ready;
  wire                    fifo_out_valid;
  wire                    fifo_out_ready;
  wire [`SSR_ENTRY_W-1:0] fifo_out_data;

  // Pin bundles and derived internal nets
  wire [`SSR_LANES-1:0]   lanes_en;
  wire [`SSR_DATA_W-1:0]  bus_in;
  wire                    selected;
  wire                    new_ok;
  wire                    fifo_push;
  wire [`SSR_ENTRY_W-1:0] fifo_in_data;
  wire [`SSR_MEM_AW-1:0]  head_idx;
  wire [`SSR_LANES-1:0]   head_lanes;
  wire [`SSR_DATA_W-1:0]  head_data;
  reg  [`SSR_DATA_W-1:0]  rd_data;
  wire                    drive_now;

  // Lane enables are active low at the pins
  assign lanes_en = ~{byte_lane3_write_n, byte_lane2_write_n,
                      byte_lane1_write_n, byte_lane0_write_n};
  assign bus_in   = {data_lane3_in, data_lane2_in, data_lane1_in, data_lane0_in};

  // All three selects must be active at a load
  assign selected = ~chip_select_n & ~chip_select2_n & chip_select_high;

  // Sleep or a full commit buffer holds off new cycles; pipeline keeps going
  assign new_ok = ~sleep_request & (slp_q == SLP_AWAKE) & fifo_in_ready;

  // Decode the edge into a cycle type and its address
  always @* begin
    c_type       = `SSR_CYC_IDLE;
    c_addr       = base_q;
    burst_type_d = burst_type_q;
    base_d       = base_q;
    cnt_d        = cnt_q;
    if (new_ok) begin
      if (~advance_load_n) begin
        if (selected) begin
          // Load external address and latch direction for the burst
          c_type       = read_write ? `SSR_CYC_READ : `SSR_CYC_WRITE;
          c_addr       = address;
          burst_type_d = c_type;
          base_d       = address;
          cnt_d        = `SSR_BURST_ZERO;
        end else begin
          burst_type_d = `SSR_CYC_IDLE;
        end
      end else if (burst_type_q != `SSR_CYC_IDLE) begin
        // Address and direction pins ignored; step the counter only
        cnt_d  = cnt_q + `SSR_BURST_ONE;
        c_type = burst_type_q;
        c_addr = {base_q[`SSR_ADDR_W-1:`SSR_BURST_W],
                  burst_lo(base_q[`SSR_BURST_W-1:0], cnt_d, burst_order)};
      end
      // Continuation after a deselect leaves c_type idle
    end
  end

  // Command pipeline and burst state, frozen while clock enable is off
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      burst_type_q <= `SSR_CYC_IDLE;
      base_q       <= {`SSR_ADDR_W{1'b0}};
      cnt_q        <= `SSR_BURST_ZERO;
      s1_type_q    <= `SSR_CYC_IDLE;
      s1_addr_q    <= {`SSR_ADDR_W{1'b0}};
      s1_lanes_q   <= {`SSR_LANES{1'b0}};
      s2_type_q    <= `SSR_CYC_IDLE;
      s2_addr_q    <= {`SSR_ADDR_W{1'b0}};
      s2_lanes_q   <= {`SSR_LANES{1'b0}};
      s3_wr_q      <= 1'b0;
      s3_addr_q    <= {`SSR_ADDR_W{1'b0}};
      s3_lanes_q   <= {`SSR_LANES{1'b0}};
    end else if (~clk_enable_n) begin
      burst_type_q <= burst_type_d;
      base_q       <= base_d;
      cnt_q        <= cnt_d;
      s1_type_q    <= c_type;
      s1_addr_q    <= c_addr;
      s1_lanes_q   <= lanes_en;
      s2_type_q    <= s1_type_q;
      s2_addr_q    <= s1_addr_q;
      s2_lanes_q   <= s1_lanes_q;
      s3_wr_q      <= (s2_type_q == `SSR_CYC_WRITE) & (|s2_lanes_q);
      s3_addr_q    <= s2_addr_q;
      s3_lanes_q   <= s2_lanes_q;
    end
  end

  // Sleep sequencing; new cycles wait until buffered writes reach the array
  always @* begin
    slp_d = slp_q;
    case (slp_q)
      SLP_AWAKE: begin
        if (sleep_request) begin
          slp_d = SLP_ASLEEP;
        end
      end
      SLP_ASLEEP: begin
        if (~sleep_request) begin
          slp_d = fifo_out_valid ? SLP_DRAIN : SLP_AWAKE;
        end
      end
      SLP_DRAIN: begin
        if (sleep_request) begin
          slp_d = SLP_ASLEEP;
        end else if (~fifo_out_valid) begin
          slp_d = SLP_AWAKE;
        end
      end
      default: begin
        slp_d = SLP_AWAKE;
      end
    endcase
  end

  // Sleep state register
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      slp_q <= SLP_AWAKE;
    end else begin
      slp_q <= slp_d;
    end
  end

  // Write data is sampled at the data edge and queued for the array
  assign fifo_push    = ~clk_enable_n & s3_wr_q;
  assign fifo_in_data = {word_index(s3_addr_q), s3_lanes_q, bus_in};

  ssr_fifo #(
    .WIDTH (`SSR_ENTRY_W),
    .DEPTH (`SSR_FIFO_DEPTH),
    .AW    (`SSR_FIFO_AW)
  ) ssr_fifo_i (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // Array stays quiet in sleep, so writes still in the pipeline wait in the buffer
  assign fifo_out_ready = ~sleep_request;
  assign head_idx   = fifo_out_data[`SSR_ENTRY_W-1 -: `SSR_MEM_AW];
  assign head_lanes = fifo_out_data[`SSR_DATA_W +: `SSR_LANES];
  assign head_data  = fifo_out_data[`SSR_DATA_W-1:0];

  // Commit one buffered write per cycle, lane by lane
  always @(posedge clk) begin
    if (fifo_out_valid & fifo_out_ready) begin
      mem_q[head_idx] <= lane_merge(mem_q[head_idx], head_data, head_lanes);
    end
  end

  // Read path forwards the buffer head and the write in its data phase; newest wins
  always @* begin
    rd_data = mem_q[word_index(s2_addr_q)];
    if (fifo_out_valid && (head_idx == word_index(s2_addr_q))) begin
      rd_data = lane_merge(rd_data, head_data, head_lanes);
    end
    if (s3_wr_q && (word_index(s3_addr_q) == word_index(s2_addr_q))) begin
      rd_data = lane_merge(rd_data, bus_in, s3_lanes_q);
    end
  end

  // Output register: read data two edges after the command
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      out_q   <= {`SSR_DATA_W{1'b0}};
      drive_q <= 1'b0;
    end else if (~clk_enable_n) begin
      if (s2_type_q == `SSR_CYC_READ) begin
        out_q   <= rd_data;
        drive_q <= 1'b1;
      end else begin
        drive_q <= 1'b0;
      end
    end
  end

  // Output enable acts without the clock; a dummy read still ran inside
  assign drive_now = drive_q & ~output_enable_n;

  // Per-lane pin drive, enable low while driving
  assign data_lane0_out  = lane_of(out_q, 2'h0);
  assign data_lane1_out  = lane_of(out_q, 2'h1);
  assign data_lane2_out  = lane_of(out_q, 2'h2);
  assign data_lane3_out  = lane_of(out_q, 2'h3);
  assign data_lane0_oe_n = ~drive_now;
  assign data_lane1_oe_n = ~drive_now;
  assign data_lane2_oe_n = ~drive_now;
  assign data_lane3_oe_n = ~drive_now;

endmodule // ssr_sram_cycles

// [ssr_regs.vh]
// Constants shared by the pipelined synchronous SRAM cycle logic
`ifndef SSR_REGS_VH
`define SSR_REGS_VH

// Data bus geometry
`define SSR_DATA_W      36
`define SSR_LANE_W      9
`define SSR_LANES       4
`define SSR_ADDR_W      18

// Flip-flop storage array
`define SSR_MEM_AW      6
`define SSR_MEM_DEPTH   64

// Write commit buffer
`define SSR_FIFO_DEPTH  8
`define SSR_FIFO_AW     3
`define SSR_ENTRY_W     46

// Burst counter
`define SSR_BURST_W     2
`define SSR_BURST_ZERO  2'h0
`define SSR_BURST_ONE   2'h1

// Cycle type carried down the pipeline
`define SSR_CYC_IDLE    2'h0
`define SSR_CYC_READ    2'h1
`define SSR_CYC_WRITE   2'h2

// Pipeline distance from command edge to data edge
`define SSR_DATA_DELAY  2

`endif

// [ssr_fifo.v]
// Parameterised flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
module ssr_fifo #(
  parameter WIDTH = 46,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset
  input  wire             clk,
  input  wire             reset,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_q;
  reg [AW-1:0]    rd_ptr_q;
  reg [AW:0]      count_q;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  // Honest flags straight from the occupancy count
  assign in_ready  = (count_q != DEPTH[AW:0]);
  assign out_valid = (count_q != {(AW+1){1'b0}});
  assign out_data  = mem_q[rd_ptr_q];

  // Storage needs no reset; only pointers and count carry control state
  always @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // Pointers wrap naturally since depth is a power of two
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push & ~pop) begin
        count_q <= count_q + {{AW{1'b0}}, 1'b1};
      end else if (pop & ~push) begin
        count_q <= count_q - {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule // ssr_fifo

// [ssr_chk.sv]
// Port-level assertions for the pipelined SRAM cycle logic
`timescale 1ns/1ps
module ssr_chk (
  // Clock and reset
  input wire       clk,
  input wire       reset,
  // Cycle controls
  input wire       clk_enable_n,
  input wire       chip_select_n,
  input wire       chip_select2_n,
  input wire       chip_select_high,
  input wire       advance_load_n,
  input wire       read_write,
  input wire       output_enable_n,
  input wire       sleep_request,
  // Data drive
  input wire [8:0] data_lane0_out,
  input wire       data_lane0_oe_n,
  input wire       data_lane1_oe_n
);
  reg  [3:0] quiet_q;
  wire       sel = !chip_select_n && !chip_select2_n && chip_select_high;
  wire       live = !clk_enable_n && !sleep_request;
  // Sleep recovery is hidden at the ports, so reads are judged only well after it
  always @(posedge clk or posedge reset) begin
    if (reset)
      quiet_q <= 4'hf;
    else if (sleep_request)
      quiet_q <= 4'h0;
    else if (quiet_q != 4'hf)
      quiet_q <= quiet_q + 4'h1;
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (reset);
  a_lane_pair: assert property (data_lane0_oe_n == data_lane1_oe_n)
    else $error("lane drive enables differ");
  a_reset_float: assert property ($fell(reset) |-> data_lane0_oe_n [*2])
    else $error("bus driven right after reset");
  a_oe_gate: assert property (output_enable_n |-> data_lane0_oe_n)
    else $error("bus driven with output enable off");
  a_desel_float: assert property ((live && !advance_load_n && !sel) ##1 !clk_enable_n ##1 !clk_enable_n
    |=> data_lane0_oe_n)
    else $error("bus driven after deselect");
  a_write_float: assert property ((live && !advance_load_n && sel && !read_write) ##1 !clk_enable_n
    ##1 !clk_enable_n |=> data_lane0_oe_n)
    else $error("bus driven in write data phase");
  a_read_drive: assert property ((live && !advance_load_n && sel && read_write && quiet_q == 4'hf)
    ##1 !clk_enable_n ##1 !clk_enable_n |=> (output_enable_n || !data_lane0_oe_n))
    else $error("read data not driven two cycles later");
  a_stall_hold: assert property (clk_enable_n ##1 $stable(output_enable_n)
    |-> $stable(data_lane0_out) && $stable(data_lane0_oe_n))
    else $error("outputs moved on an ignored edge");
  a_cont_desel: assert property ((live && !advance_load_n && !sel && quiet_q == 4'hf)
    ##1 (live && advance_load_n) ##2 !clk_enable_n |=> data_lane0_oe_n)
    else $error("continuation after deselect drove the bus");
endmodule // ssr_chk

bind ssr_sram_cycles ssr_chk ssr_chk_i (.*);

// [ssr_host.sv]
// Controller model: write data two cycles after the command, bus resolution
`timescale 1ns/1ps
module ssr_host (
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  input  wire        clk_enable_n,
  // Write request from the bench
  input  wire        go,
  input  wire [35:0] word,
  // Device drive and resolved bus
  input  wire [35:0] dev_out,
  input  wire        dev_oe_n,
  output wire [35:0] bus
);
  reg [2:0]  go_q;
  reg [35:0] w1_q, w2_q, w3_q, last_q;
  // Data phase counted in enabled edges only; idle bus toggles so stale data never matches
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      go_q <= 3'h0;
      last_q <= 36'h0;
    end else begin
      last_q <= bus;
      if (!clk_enable_n) begin
        go_q <= {go_q[1:0], go};
        w1_q <= word;
        w2_q <= w1_q;
        w3_q <= w2_q;
      end
    end
  end
  assign bus = !dev_oe_n ? dev_out : go_q[2] ? w3_q : ~last_q;
endmodule // ssr_host

// [ssr_sram_cycles_tb.sv]
// Self-checking bench for the pipelined SRAM cycle logic
`timescale 1ns/1ps
module ssr_sram_cycles_tb;
  reg clk = 1'b0, reset = 1'b1, clk_enable_n = 1'b0, chip_select_n = 1'b1, chip_select2_n = 1'b0;
  reg chip_select_high = 1'b1, advance_load_n = 1'b0, read_write = 1'b1, output_enable_n = 1'b0;
  reg burst_order = 1'b1, sleep_request = 1'b0, go = 1'b0;
  reg [17:0] address = 18'h0;
  reg [3:0] ln = 4'hf;
  reg [35:0] word = 36'h0;
  wire [35:0] bus;
  wire byte_lane0_write_n = ln[0], byte_lane1_write_n = ln[1], byte_lane2_write_n = ln[2], byte_lane3_write_n = ln[3];
  wire [8:0] data_lane0_in = bus[8:0], data_lane1_in = bus[17:9], data_lane2_in = bus[26:18], data_lane3_in = bus[35:27];
  wire [8:0] data_lane0_out, data_lane1_out, data_lane2_out, data_lane3_out;
  wire data_lane0_oe_n, data_lane1_oe_n, data_lane2_oe_n, data_lane3_oe_n;
  wire [35:0] dev_out = {data_lane3_out, data_lane2_out, data_lane1_out, data_lane0_out};
  wire [3:0] oes = {data_lane3_oe_n, data_lane2_oe_n, data_lane1_oe_n, data_lane0_oe_n};
  integer num_errors = 0, comparisons = 0, ecyc = 0, i, k;
  reg [1:0] kind [0:1023];
  reg [35:0] expv [0:1023];
  reg [35:0] mem [0:63];
  reg [1:0] bdir = 2'h0, bk = 2'h0;
  reg [5:0] bst = 6'h0;

  ssr_sram_cycles ssr_sram_cycles_i (.*);
  ssr_host ssr_host_i (.clk(clk), .reset(reset), .clk_enable_n(clk_enable_n), .go(go), .word(word),
                       .dev_out(dev_out), .dev_oe_n(data_lane0_oe_n), .bus(bus));

  always #5 clk = ~clk;

  task chk(input [35:0] got, input [35:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
    end
  endtask
  // Falling edge; judges the data phase of this cycle, held while the clock is ignored
  task tick;
    begin
      @(negedge clk);
      if (!clk_enable_n)
        ecyc = ecyc + 1;
      if (kind[ecyc] == 2'h2 && !output_enable_n) begin
        chk({32'h0, oes}, 36'h0);
        chk(dev_out, expv[ecyc]);
      end else if (kind[ecyc] != 2'h0) begin
        chk({32'h0, oes}, 36'hf);
      end
    end
  endtask
  // Op 0 deselect (a picks the select), 1 read, 2 write, 3 continue
  task cmd(input [1:0] op, input [5:0] a, input [3:0] l, input [35:0] d);
    reg [5:0] ea;
    begin
      tick;
      ea = a;
      advance_load_n = op == 2'h3;
      read_write = op == 2'h3 ? bdir == 2'h2 : op != 2'h2;
      chip_select_n = op == 2'h0 ? a[1:0] == 2'h0 : op == 2'h3;
      chip_select2_n = op == 2'h0 && a[1:0] == 2'h1;
      chip_select_high = !(op == 2'h0 && a[1:0] == 2'h2);
      address = op == 2'h3 ? 18'h3ffff : {12'h0, a};
      ln = l;
      word = d;
      kind[ecyc + 3] = 2'h1;
      if (!sleep_request && op == 2'h3 && bdir != 2'h0) begin
        bk = bk + 2'h1;
        ea = {bst[5:2], burst_order ? bst[1:0] ^ bk : bst[1:0] + bk};
        op = bdir;
      end else if (!sleep_request && op != 2'h3) begin
        bdir = op;
        bst = a;
        bk = 2'h0;
      end
      go = !sleep_request && op == 2'h2 && l != 4'hf;
      if (!sleep_request && op == 2'h1) begin
        kind[ecyc + 3] = 2'h2;
        expv[ecyc + 3] = mem[ea];
      end
      for (i = 0; i < 4; i = i + 1)
        if (go && !l[i]) mem[ea][9 * i +: 9] = d[9 * i +: 9];
    end
  endtask
  // Three deselects so every data phase of a scenario is judged inside it
  task drain;
    begin
      repeat (3) cmd(2'h0, 6'h00, 4'h0, 36'h0);
    end
  endtask
  task t_power;
    begin
      repeat (8) begin
        tick;
        chk({32'h0, oes}, 36'hf);
      end
      reset = 1'b0;
      tick;
      chk({32'h0, oes}, 36'hf);
    end
  endtask
  // Back-to-back writes, partial lanes, an aborted write, forwarded reads
  task t_rw;
    begin
      cmd(2'h2, 6'h04, 4'h0, 36'h123456789);
      cmd(2'h1, 6'h04, 4'h0, 36'h0);
      cmd(2'h2, 6'h08, 4'h0, 36'h0);
      cmd(2'h2, 6'h08, 4'ha, 36'hfffffffff);
      cmd(2'h2, 6'h08, 4'hf, 36'h5a5a5a5a5);
      cmd(2'h1, 6'h08, 4'h0, 36'h0);
      cmd(2'h1, 6'h04, 4'h0, 36'h0);
      drain;
    end
  endtask
  // Eight beats wrap twice; beat 4 partial, beat 5 all lanes off
  task t_burst(input o, input [5:0] a);
    begin
      burst_order = o;
      for (k = 0; k < 8; k = k + 1)
        cmd(k ? 2'h3 : 2'h2, a, k == 4 ? 4'h6 : k == 5 ? 4'hf : 4'h0, 36'h111111111 * k + o);
      for (k = 0; k < 8; k = k + 1)
        cmd(k ? 2'h3 : 2'h1, a, 4'h0, 36'h0);
      drain;
    end
  endtask
  // Dummy reads and an aborted write still step the counter
  task t_dummy;
    begin
      output_enable_n = 1'b1;
      for (k = 0; k < 6; k = k + 1) begin
        cmd(k ? 2'h3 : 2'h1, 6'h12, 4'h0, 36'h0);
        if (k == 3)
          output_enable_n = 1'b0;
      end
      cmd(2'h2, 6'h30, 4'hf, 36'h0);
      cmd(2'h3, 6'h00, 4'h0, 36'h0abcabcab);
      cmd(2'h1, 6'h31, 4'h0, 36'h0);
      drain;
    end
  endtask
  task t_desel;
    begin
      for (k = 0; k < 3; k = k + 1) begin
        cmd(2'h1, 6'h04, 4'h0, 36'h0);
        cmd(2'h0, k[5:0], 4'h0, 36'h0);
        cmd(2'h3, 6'h00, 4'h0, 36'h0);
      end
      drain;
    end
  endtask
  task t_stall;
    begin
      cmd(2'h1, 6'h04, 4'h0, 36'h0);
      cmd(2'h1, 6'h08, 4'h0, 36'h0);
      cmd(2'h0, 6'h00, 4'h0, 36'h0);
      tick;
      clk_enable_n = 1'b1;
      repeat (3) tick;
      clk_enable_n = 1'b0;
      repeat (3) cmd(2'h0, 6'h00, 4'h0, 36'h0);
    end
  endtask
  // Sleep two cycles after the last write; commands meanwhile are dropped
  task t_sleep;
    begin
      cmd(2'h2, 6'h04, 4'h0, 36'h0fedcba98);
      repeat (2) cmd(2'h0, 6'h00, 4'h0, 36'h0);
      sleep_request = 1'b1;
      cmd(2'h1, 6'h04, 4'h0, 36'h0);
      cmd(2'h2, 6'h04, 4'h0, 36'h0);
      cmd(2'h0, 6'h00, 4'h0, 36'h0);
      sleep_request = 1'b0;
      repeat (8) cmd(2'h0, 6'h00, 4'h0, 36'h0);
      cmd(2'h1, 6'h04, 4'h0, 36'h0);
      repeat (3) cmd(2'h0, 6'h00, 4'h0, 36'h0);
    end
  endtask
  task results;
    begin
      $display("comparisons %0d, errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
        $display("No errors found");
      end else begin
        $display("Errors were found");
      end
      $finish;
    end
  endtask

  initial begin
    for (i = 0; i < 1024; i = i + 1)
      kind[i] = 2'h0;
    t_power;
    t_rw;
    t_burst(1'b1, 6'h12);
    t_burst(1'b0, 6'h21);
    t_dummy;
    t_desel;
    t_stall;
    t_sleep;
    results;
  end
  // Watchdog: the run needs about 110 cycles
  initial begin
    #20000;
    num_errors = num_errors + 1;
    results;
  end
endmodule // ssr_sram_cycles_tb
